// >>> shared/nps_pkg.sv
// Constants and types for the NAND power-up and sleep host sequencer
package nps_pkg;
	localparam int CLK_PERIOD_NS = 8;
	// Power-on initialization, typical figure, in microseconds
	localparam int INIT_TIME_US = 20;
	// Idle time with select high before the device sleeps, in microseconds
	localparam int SLEEP_IDLE_US = 10;
	// Wake setup time after select goes active, in microseconds
	localparam int WAKE_SETUP_TIME_US = 2;
	// Guard settle time after the write guard falls, in nanoseconds
	localparam int GUARD_SETTLE_TIME_NS = 100;
	// Least waits round up, longest waits round down, never below one cycle
	localparam int INIT_CYCLES = (INIT_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SLEEP_IDLE_CYCLES = (SLEEP_IDLE_US * 1000) / CLK_PERIOD_NS;
	localparam int WAKE_SETUP_CYCLES =
		(WAKE_SETUP_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int GUARD_SETTLE_CYCLES =
		(GUARD_SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W = 16;
	// Sequencer states
	typedef enum logic [2:0] {
		NPS_POWER_OFF,
		NPS_WAIT_INIT,
		NPS_WAIT_READY,
		NPS_IDLE,
		NPS_SLEEP,
		NPS_WAKE,
		NPS_ACTIVE,
		NPS_GUARD
	} nps_state_t;
endpackage

// >>> rtl/nps_timer.sv
// Down-counting delay timer with load and done flag
module nps_timer #(
	parameter int WIDTH = 16
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic load,
	input wire logic [WIDTH-1:0] count,
	output logic done
);
	logic [WIDTH-1:0] remain;
	wire logic at_zero = (remain == '0);

	initial begin
		if (WIDTH < 2)
			$error("nps_timer WIDTH too small");
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			remain <= '0;
		else if (load)
			remain <= count;
		else if (!at_zero)
			remain <= remain - 1'b1;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			done <= 1'b0;
		else
			done <= !load && (remain == {{(WIDTH-1){1'b0}}, 1'b1} || at_zero);
	end
endmodule

// >>> rtl/nps_host.sv
// Host-side power-up, boot-wait and sleep/wake sequencer for a NAND flash

// Device and host rules this block is built around
// RULE_01: Device loads page 0 into cache after init; host reads it without command.
// RULE_02: Host programs pages of a block only in ascending order.
// RULE_03: Device shows busy on ready/busy while its power-on init runs.
// RULE_04: Device loads register defaults during init before accepting operations.
// RULE_05: Init takes about 20 us; host waits for ready before first command.
// RULE_06: Host holds write guard low throughout power-on and power-off.
// RULE_07: Device sleeps after select stays inactive 10 us with no command.
// RULE_08: Device wakes as soon as select goes active; no command needed.
// RULE_09: Host waits at least 2 us after waking before next operation.
// RULE_10: Write guard low aborts program or erase; allow 100 ns settle.
// RULE_11: Ready/busy reads 0 when busy and 1 when ready.
// RULE_12: Device stays busy until the automatic page 0 load completes.
module nps_host #(
	parameter int INIT_WAIT = nps_pkg::INIT_CYCLES,
	parameter int SLEEP_WAIT = nps_pkg::SLEEP_IDLE_CYCLES,
	parameter int WAKE_WAIT = nps_pkg::WAKE_SETUP_CYCLES,
	parameter int GUARD_WAIT = nps_pkg::GUARD_SETTLE_CYCLES,
	parameter int PAGE_W = 6
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic power_good,
	input wire logic power_down_req,
	input wire logic op_req,
	input wire logic op_done,
	input wire logic op_is_program,
	input wire logic [PAGE_W-1:0] op_page,
	input wire logic op_new_block,
	input wire logic nand_ready,
	output logic nand_select_n,
	output logic nand_guard_n,
	output logic op_grant,
	output logic op_refused,
	output logic boot_ready,
	output logic asleep,
	output nps_pkg::nps_state_t state
);
	import nps_pkg::*;

	nps_state_t next_state;
	logic [PAGE_W:0] next_page;
	logic page_seen;
	logic tmr_load;
	logic [CNT_W-1:0] tmr_count;
	logic tmr_done;
	logic op_answered;

	initial begin
		if (INIT_WAIT < 1 || INIT_WAIT >= 2 ** CNT_W || SLEEP_WAIT < 1 ||
			SLEEP_WAIT >= 2 ** CNT_W || WAKE_WAIT < 1 || WAKE_WAIT >= 2 ** CNT_W ||
			GUARD_WAIT < 1 || GUARD_WAIT >= 2 ** CNT_W || PAGE_W < 1 || PAGE_W > 15)
			$error("nps_host parameter out of range");
	end

	function automatic logic [CNT_W-1:0] cyc(input int n);
		return CNT_W'(n);
	endfunction

	// Ready is level 1, busy is level 0 on the ready/busy pin
	wire logic dev_ready = (nand_ready == 1'b1);
	// A fresh block restarts the page order; the first program is free
	wire logic in_order = op_new_block ? 1'b1 :
		({1'b0, op_page} == next_page) || !page_seen;
	wire logic prog_bad = op_is_program && !in_order;
	wire logic take_op = op_req && dev_ready && !prog_bad;
	wire logic idle_like = (state == NPS_IDLE) || (state == NPS_SLEEP);

	always_comb begin
		next_state = state;
		tmr_load = 1'b0;
		tmr_count = '0;
		unique case (state)
			NPS_POWER_OFF: begin
				if (power_good) begin
					next_state = NPS_WAIT_INIT;
					tmr_load = 1'b1;
					tmr_count = cyc(INIT_WAIT);
				end
			end
			NPS_WAIT_INIT: begin
				// RULE_05 wait init time
				if (tmr_done)
					next_state = NPS_WAIT_READY;
			end
			NPS_WAIT_READY: begin
				// RULE_12 wait page0 load
				if (dev_ready)
					next_state = NPS_IDLE;
			end
			NPS_IDLE: begin
				if (power_down_req) begin
					next_state = NPS_GUARD;
					tmr_load = 1'b1;
					tmr_count = cyc(GUARD_WAIT);
				end else if (op_req) begin
					next_state = NPS_ACTIVE;
				end else if (tmr_done) begin
					next_state = NPS_SLEEP;
				end
			end
			NPS_SLEEP: begin
				if (power_down_req) begin
					next_state = NPS_GUARD;
					tmr_load = 1'b1;
					tmr_count = cyc(GUARD_WAIT);
				end else if (op_req) begin
					// RULE_08 select wakes
					next_state = NPS_WAKE;
					tmr_load = 1'b1;
					tmr_count = cyc(WAKE_WAIT);
				end
			end
			NPS_WAKE: begin
				// RULE_09 wake setup wait
				if (tmr_done)
					next_state = NPS_ACTIVE;
			end
			NPS_ACTIVE: begin
				// Sleep count restarts on each return to idle
				if (op_done || op_refused) begin
					next_state = NPS_IDLE;
					tmr_load = 1'b1;
					tmr_count = cyc(SLEEP_WAIT);
				end
			end
			NPS_GUARD: begin
				// RULE_10 guard settle
				if (tmr_done && !power_good)
					next_state = NPS_POWER_OFF;
			end
		endcase
		if (idle_like && state != next_state && next_state == NPS_IDLE)
			tmr_load = 1'b1;
		if (state == NPS_WAIT_READY && next_state == NPS_IDLE) begin
			tmr_load = 1'b1;
			tmr_count = cyc(SLEEP_WAIT);
		end
	end

	// One shared timer serves init, sleep, wake and guard waits
	nps_timer #(
		.WIDTH(CNT_W)
	) u_timer (
		.clk(clk),
		.reset_n(reset_n),
		.load(tmr_load),
		.count(tmr_count),
		.done(tmr_done)
	);

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			state <= NPS_POWER_OFF;
		else
			state <= next_state;
	end

	// RULE_06 guard low at power edges
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			nand_guard_n <= 1'b0;
		else
			nand_guard_n <= (next_state == NPS_IDLE) || (next_state == NPS_SLEEP) ||
				(next_state == NPS_WAKE) || (next_state == NPS_ACTIVE);
	end

	// RULE_07 select high lets sleep
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			nand_select_n <= 1'b1;
		else
			nand_select_n <= !((next_state == NPS_WAKE) || (next_state == NPS_ACTIVE));
	end

	// RULE_02 ascending page order
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			next_page <= '0;
			page_seen <= 1'b0;
		end else if (state == NPS_ACTIVE && op_grant && op_is_program) begin
			next_page <= {1'b0, op_page} + 1'b1;
			page_seen <= 1'b1;
		end
	end

	// RULE_11 grant only when ready
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			op_grant <= 1'b0;
			op_refused <= 1'b0;
		end else begin
			op_grant <= (state == NPS_ACTIVE) && take_op && !op_grant && !op_refused &&
				!op_answered;
			op_refused <= (state == NPS_ACTIVE) && op_req && prog_bad &&
				!op_grant && !op_refused && !op_answered;
		end
	end

	// One answer per active period, as op_req stays high until op_done
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			op_answered <= 1'b0;
		else
			op_answered <= (next_state == NPS_ACTIVE) &&
				(op_answered || op_grant || op_refused);
	end

	// RULE_01 boot page readable
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			boot_ready <= 1'b0;
			asleep <= 1'b0;
		end else begin
			boot_ready <= (next_state != NPS_POWER_OFF) && (next_state != NPS_WAIT_INIT) &&
				(next_state != NPS_WAIT_READY) && (next_state != NPS_GUARD);
			asleep <= (next_state == NPS_SLEEP);
		end
	end
endmodule

// >>> test/nps_flash.sv
// Behavioural flash device: busy through init and page-0 load, auto sleep
module nps_flash #(
	parameter int INIT_T = 40,
	parameter int IDLE_T = 4,
	parameter int GUARD_T = 13
) (
	input wire logic clk,
	input wire logic power_good,
	input wire logic select_n,
	input wire logic guard_n,
	output logic nand_ready,
	output logic sleeping = 1'b0,
	output logic loaded = 1'b0,
	output logic settled = 1'b0
);
	timeunit 1ns;
	timeprecision 1ps;
	int init_cnt = 0;
	int idle_cnt = 0;
	int guard_cnt = 0;
	always @(posedge clk) begin
		guard_cnt <= guard_n ? 0 : guard_cnt + 1;
		settled <= !guard_n && guard_cnt >= GUARD_T - 1;
	end
	assign nand_ready = loaded;
	always @(posedge clk) begin
		init_cnt <= power_good ? init_cnt + 1 : 0;
		loaded <= power_good && init_cnt >= INIT_T;
	end
	// sleep on idle, wake on select
	always @(posedge clk) begin
		idle_cnt <= select_n ? idle_cnt + 1 : 0;
		sleeping <= select_n && idle_cnt >= IDLE_T;
	end
endmodule

// >>> test/nps_host_props.sv
// Port assertions for the host sequencer
module nps_props
	import nps_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic power_down_req,
	input wire logic op_req,
	input wire logic nand_ready,
	input wire logic nand_select_n,
	input wire logic nand_guard_n,
	input wire logic op_grant,
	input wire logic op_refused,
	input wire logic boot_ready,
	input wire logic asleep,
	input wire nps_pkg::nps_state_t state
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	AST_GUARD_BOOT: assert property (
		state inside {NPS_POWER_OFF, NPS_WAIT_INIT, NPS_WAIT_READY} |-> !nand_guard_n)
		else $error("guard high before boot");
	AST_GUARD_OFF: assert property (
		state == NPS_IDLE && power_down_req && !op_req |-> ##[1:4] !nand_guard_n)
		else $error("guard not lowered for power down");
	AST_BOOT_READY: assert property ($rose(boot_ready) |-> $past(nand_ready))
		else $error("boot ready while device busy");
	AST_INIT_WAIT: assert property ($rose(state == NPS_WAIT_INIT) |-> !boot_ready[*4])
		else $error("boot ready too early");
	AST_GRANT_READY: assert property (op_grant |-> $past(nand_ready))
		else $error("grant while busy");
	AST_WAKE: assert property (state == NPS_SLEEP && op_req |-> !op_grant[*5])
		else $error("grant inside wake setup");
	AST_SEL_GRANT: assert property (op_grant |-> !nand_select_n && !op_refused)
		else $error("grant without select");
	AST_ANSWER: assert property (
		state == NPS_IDLE && op_req && nand_ready |-> ##[1:8] (op_grant || op_refused))
		else $error("request left unanswered");
	C_GRANT: cover property (op_grant);
	C_REFUSE: cover property (op_refused);
	C_SLEEP: cover property ($rose(asleep));
endmodule

bind nps_host nps_props u_props (
	.clk(clk),
	.reset_n(reset_n),
	.power_down_req(power_down_req),
	.op_req(op_req),
	.nand_ready(nand_ready),
	.nand_select_n(nand_select_n),
	.nand_guard_n(nand_guard_n),
	.op_grant(op_grant),
	.op_refused(op_refused),
	.boot_ready(boot_ready),
	.asleep(asleep),
	.state(state)
);

// >>> test/testbench.sv
// Bench for the NAND power-up and sleep host sequencer
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import nps_pkg::*;
	logic clk = 0, reset_n = 0, power_good = 0, power_down_req = 0, op_req = 0;
	logic op_done = 0, op_is_program = 0, op_new_block = 0, g;
	logic [5:0] op_page = '0;
	logic nand_ready, nand_select_n, nand_guard_n, op_grant, op_refused, boot_ready, asleep;
	logic slp, ld, stl;
	nps_state_t state;
	int fails = 0, samples_checked = 0, seed = 69157, last_pg = -1, k, pg;
	initial begin
		forever #4 clk = ~clk;
	end
	nps_host #(.INIT_WAIT(4), .SLEEP_WAIT(4), .WAKE_WAIT(4)) DUT (
		.clk(clk),
		.reset_n(reset_n),
		.power_good(power_good),
		.power_down_req(power_down_req),
		.op_req(op_req),
		.op_done(op_done),
		.op_is_program(op_is_program),
		.op_page(op_page),
		.op_new_block(op_new_block),
		.nand_ready(nand_ready),
		.nand_select_n(nand_select_n),
		.nand_guard_n(nand_guard_n),
		.op_grant(op_grant),
		.op_refused(op_refused),
		.boot_ready(boot_ready),
		.asleep(asleep),
		.state(state)
	);
	nps_flash u_flash (.clk(clk), .power_good(power_good), .select_n(nand_select_n),
		.guard_n(nand_guard_n), .nand_ready(nand_ready), .sleeping(slp), .loaded(ld),
		.settled(stl));
	task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic give_verdict;
		if (fails == 0 && samples_checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic wait_on(input int c);
		k = 0;
		while ((c == 0 ? boot_ready : c == 1 ? op_grant | op_refused :
			c == 2 ? asleep : state == NPS_POWER_OFF) !== 1'b1) begin
			@(posedge clk);
			#1;
			k++;
			if (k > 300) begin
				fails++;
				give_verdict();
			end
		end
	endtask
	task automatic do_op(input logic prog, input int p, input logic nb);
		logic er;
		er = prog && !nb && last_pg >= 0 && p != last_pg + 1;
		@(posedge clk);
		op_req <= 1;
		op_is_program <= prog;
		op_page <= p[5:0];
		op_new_block <= nb;
		wait_on(1);
		g = op_grant;
		check("refused", op_refused, er);
		if (g) check("ready", nand_ready, 1);
		if (g) check("select", nand_select_n, 0);
		if (prog && !er) last_pg = p;
		if (g) repeat (3) begin
			@(posedge clk);
			#1;
			check("one_grant", op_grant, 0);
		end
		@(posedge clk);
		op_req <= 0;
		op_done <= g;
		@(posedge clk);
		op_done <= 0;
	endtask
	initial begin
		repeat (16) @(posedge clk);
		reset_n <= 1;
		@(posedge clk);
		power_good <= 1;
		wait_on(0);
		check("boot_wait", k >= 40, 1);
		check("page0", ld, 1);
		check("guard", nand_guard_n, 1);
		do_op(1'b1, 5, 1'b1);
		for (int i = 0; i < 12; i++) begin
			pg = ($random(seed) & 3) != 0 ? last_pg + 1 : $random(seed) & 31;
			do_op(1'($random(seed)), pg, 1'b0);
		end
		wait_on(2);
		repeat (8) @(posedge clk);
		#1;
		check("dev_sleep", slp, 1);
		do_op(1'b0, 0, 1'b0);
		check("wake_wait", k >= 4, 1);
		check("awake", slp, 0);
		check("asleep", asleep, 0);
		power_down_req <= 1;
		repeat (8) @(posedge clk);
		#1;
		check("guard_off", nand_guard_n, 0);
		@(posedge clk);
		power_good <= 0;
		wait_on(3);
		check("settle", stl, 1);
		check("off_guard", nand_guard_n, 0);
		give_verdict();
	end
endmodule
